// ### shared/clr_pkg.sv
`default_nettype none
package clr_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int T_POR_ASSERT_NS = 3000;
  localparam int T_BOD_ASSERT_NS = 3000;
  localparam int T_BOD_ACTIVE_NS = 55000;
  localparam int T_BOD_ENABLE_NS = 35000;
  localparam int POR_ASSERT_CYC = (T_POR_ASSERT_NS * 1000) / CLK_PERIOD_PS;
  localparam int BOD_ASSERT_CYC = (T_BOD_ASSERT_NS * 1000) / CLK_PERIOD_PS;
  localparam int BOD_ACTIVE_CYC = (T_BOD_ACTIVE_NS * 1000) / CLK_PERIOD_PS;
  localparam int BOD_ENABLE_CYC = (T_BOD_ENABLE_NS * 1000) / CLK_PERIOD_PS;
  localparam int CNT_W = 16;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INT_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INT_MASK = 8'h0C;

  // ==========================================================
  // field positions
  localparam int CTRL_BOD_EN_BIT = 0;
  localparam int ST_POR_N_BIT = 0;
  localparam int ST_BOD_N_BIT = 1;
  localparam int ST_BOD_ACTIVE_BIT = 2;
  localparam int ST_CAUSE_LSB = 8;
  localparam int ST_RESTART_BIT = 12;
  localparam int INT_RELEASE_BIT = 0;
  localparam int INT_BROWNOUT_BIT = 1;
  localparam int INT_RESTART_BIT = 2;
  localparam int INT_W = 3;

  // ==========================================================
  // reset values
  localparam logic CTRL_BOD_EN_RST = 1'b1;
  localparam logic [2:0] CAUSE_RST = 3'h1;
  localparam logic [INT_W-1:0] INT_MASK_RST = 3'h0;

  typedef enum logic [1:0] {
    BOD_OFF,
    BOD_WAIT,
    BOD_ON
  } clr_bod_e;
endpackage : clr_pkg
`default_nettype wire

// ### logic/clr_chip_reset.sv
// Functional notes
// - two resets: main chip, debug port only
// - both held on power-on, brown-out, run low
// - debug restart holds main reset only
// - main reset rising hands over to sequencer
// - power-on release after supply good delay
// - power-on output stays high unless brown-out
// - brown-out trips after persistent low supply
// - brown-out trip restarts power-on reset
// - detection auto-enabled, active after activation delay
// - software bit disables or re-enables detection
// - re-enable waits enable delay before acting
// - disabled detection forces brown-out output high
// - any register reset sets enable bit
// - supply reset activation delay, others enable delay only if detection was off
// - one-hot cause flags of last reset
// - debug restart sets persistent restart flag
// - release once run high, others released
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module clr_chip_reset
  import clr_pkg::*;
#(
  parameter int BOD_ACTIVE_CNT = BOD_ACTIVE_CYC,
  parameter int BOD_ENABLE_CNT = BOD_ENABLE_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic core_supply_good,
  input wire logic core_supply_low,
  input wire logic run_pin,
  input wire logic debug_restart_req,
  output logic main_reset_n,
  output logic debug_port_reset_n,
  output logic irq
);

  // ==========================================================
  // synchronisers
  logic run_s1_r;
  logic run_s2_r;
  logic good_s1_r;
  logic good_s2_r;
  logic low_s1_r;
  logic low_s2_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_s1_r <= 1'b0;
      run_s2_r <= 1'b0;
      good_s1_r <= 1'b0;
      good_s2_r <= 1'b0;
      low_s1_r <= 1'b0;
      low_s2_r <= 1'b0;
    end else begin
      run_s1_r <= run_pin;
      run_s2_r <= run_s1_r;
      good_s1_r <= core_supply_good;
      good_s2_r <= good_s1_r;
      low_s1_r <= core_supply_low;
      low_s2_r <= low_s1_r;
    end
  end

  // ==========================================================
  // power-on reset
  logic por_n_r;
  logic bod_n_r;
  logic [CNT_W-1:0] por_cnt_r;
  logic [CNT_W-1:0] por_cnt_nxt;
  logic por_n_nxt;
  wire logic por_done = good_s2_r && (por_cnt_r == CNT_W'(POR_ASSERT_CYC));

  always_comb begin
    por_n_nxt = por_n_r;
    por_cnt_nxt = por_cnt_r;
    if (!bod_n_r) begin
      por_n_nxt = 1'b0;
      por_cnt_nxt = '0;
    end else if (!por_n_r) begin
      if (!good_s2_r) begin
        por_cnt_nxt = '0;
      end else if (por_done) begin
        por_n_nxt = 1'b1;
      end else begin
        por_cnt_nxt = por_cnt_r + 1'b1;
      end
    end
  end

  // once high, a falling supply alone never pulls it back down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_n_r <= 1'b0;
      por_cnt_r <= '0;
    end else begin
      por_n_r <= por_n_nxt;
      por_cnt_r <= por_cnt_nxt;
    end
  end

  // ==========================================================
  // reset outputs
  // run low asserts both resets without waiting for the synchroniser
  wire logic run_ok = run_pin && run_s2_r;
  assign debug_port_reset_n = run_ok && por_n_r;
  assign main_reset_n = debug_port_reset_n && !debug_restart_req;

  // ==========================================================
  // brown-out detection enable and activation
  logic bod_en_r;
  clr_bod_e bod_st_r;
  clr_bod_e bod_st_nxt;
  logic sel_act_r;
  logic sel_act_nxt;
  logic [CNT_W-1:0] wait_cnt_r;
  logic [CNT_W-1:0] wait_cnt_nxt;
  wire logic [CNT_W-1:0] wait_target =
    sel_act_r ? CNT_W'(BOD_ACTIVE_CNT) : CNT_W'(BOD_ENABLE_CNT);
  // gated by the enable so a cleared bit silences the trip at once, not a cycle later
  wire logic bod_active = (bod_st_r == BOD_ON) && bod_en_r;

  always_comb begin
    bod_st_nxt = bod_st_r;
    sel_act_nxt = sel_act_r;
    wait_cnt_nxt = wait_cnt_r;
    if (!por_n_r) begin
      bod_st_nxt = BOD_WAIT;
      sel_act_nxt = 1'b1;
      wait_cnt_nxt = '0;
    end else if (!bod_en_r) begin
      bod_st_nxt = BOD_OFF;
    end else begin
      case (bod_st_r)
        BOD_OFF: begin
          bod_st_nxt = BOD_WAIT;
          sel_act_nxt = 1'b0;
          wait_cnt_nxt = '0;
        end
        BOD_WAIT: begin
          if (wait_cnt_r == wait_target) begin
            bod_st_nxt = BOD_ON;
          end else begin
            wait_cnt_nxt = wait_cnt_r + 1'b1;
          end
        end
        BOD_ON: begin
          bod_st_nxt = BOD_ON;
        end
        default: begin
          bod_st_nxt = BOD_OFF;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_st_r <= BOD_WAIT;
      sel_act_r <= 1'b1;
      wait_cnt_r <= '0;
    end else begin
      bod_st_r <= bod_st_nxt;
      sel_act_r <= sel_act_nxt;
      wait_cnt_r <= wait_cnt_nxt;
    end
  end

  // ==========================================================
  // brown-out trip
  logic [CNT_W-1:0] bod_cnt_r;
  logic [CNT_W-1:0] bod_cnt_nxt;
  logic bod_n_nxt;

  always_comb begin
    bod_n_nxt = 1'b1;
    bod_cnt_nxt = '0;
    if (bod_active && low_s2_r) begin
      if (bod_cnt_r == CNT_W'(BOD_ASSERT_CYC)) begin
        bod_n_nxt = 1'b0;
        bod_cnt_nxt = bod_cnt_r;
      end else begin
        bod_cnt_nxt = bod_cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_n_r <= 1'b1;
      bod_cnt_r <= '0;
    end else begin
      bod_n_r <= bod_n_nxt;
      bod_cnt_r <= bod_cnt_nxt;
    end
  end

  // ==========================================================
  // bus slave: zero wait states, read data fetched in address phase
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [INT_W-1:0] int_st_r;
  logic [INT_W-1:0] int_mask_r;
  logic [2:0] cause_r;
  logic restart_r;
  wire logic addr_ph = hsel && hready && htrans[1];
  wire logic [7:0] a_off = haddr[7:0];
  wire logic wr_ctrl = wr_pend_r && (wr_addr_r == ADDR_CTRL);
  wire logic wr_status = wr_pend_r && (wr_addr_r == ADDR_STATUS);
  wire logic wr_int = wr_pend_r && (wr_addr_r == ADDR_INT_STATUS);
  wire logic wr_mask = wr_pend_r && (wr_addr_r == ADDR_INT_MASK);
  wire logic [31:0] status_word = {19'h0, restart_r, 1'b0, cause_r, 5'h0,
                                   bod_active, bod_n_r, por_n_r};
  wire logic [31:0] rd_word =
    (a_off == ADDR_CTRL) ? {31'h0, bod_en_r} :
    (a_off == ADDR_STATUS) ? status_word :
    (a_off == ADDR_INT_STATUS) ? {29'h0, int_st_r} :
    (a_off == ADDR_INT_MASK) ? {29'h0, int_mask_r} : 32'h0000_0000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend_r <= addr_ph && hwrite;
      wr_addr_r <= addr_ph ? a_off : wr_addr_r;
      hrdata <= (addr_ph && !hwrite) ? rd_word : hrdata;
    end
  end

  // ==========================================================
  // control register: held at its reset value while the chip is in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bod_en_r <= CTRL_BOD_EN_RST;
    end else if (!main_reset_n) begin
      bod_en_r <= CTRL_BOD_EN_RST;
    end else if (wr_ctrl) begin
      bod_en_r <= hwdata[CTRL_BOD_EN_BIT];
    end
  end

  // ==========================================================
  // reset cause and restart flag
  function automatic logic [INT_W-1:0] set_w1c(input logic [INT_W-1:0] cur,
                                               input logic [INT_W-1:0] set,
                                               input logic [INT_W-1:0] clr);
    // a set in the clearing cycle survives
    set_w1c = (cur & ~clr) | set;
  endfunction : set_w1c

  wire logic src_sup = !por_n_r;
  wire logic src_pin = !run_ok;
  wire logic [2:0] cause_nxt = {debug_restart_req && !src_pin && !src_sup,
                                src_pin && !src_sup, src_sup};
  wire logic [INT_W-1:0] rst_clr = {2'h0, wr_status && hwdata[ST_RESTART_BIT]};
  wire logic [INT_W-1:0] rst_flag = set_w1c({2'h0, restart_r}, {2'h0, debug_restart_req}, rst_clr);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_r <= CAUSE_RST;
      restart_r <= 1'b0;
    end else begin
      cause_r <= main_reset_n ? cause_r : cause_nxt;
      restart_r <= rst_flag[0];
    end
  end

  // ==========================================================
  // interrupts
  logic main_q_r;
  logic bod_q_r;
  logic dbg_q_r;
  wire logic [INT_W-1:0] ev = {debug_restart_req && !dbg_q_r, !bod_n_r && bod_q_r,
                               main_reset_n && !main_q_r};
  wire logic [INT_W-1:0] int_clr = wr_int ? hwdata[INT_W-1:0] : '0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      main_q_r <= 1'b0;
      bod_q_r <= 1'b1;
      dbg_q_r <= 1'b0;
      int_st_r <= '0;
      int_mask_r <= INT_MASK_RST;
    end else begin
      main_q_r <= main_reset_n;
      bod_q_r <= bod_n_r;
      dbg_q_r <= debug_restart_req;
      int_st_r <= set_w1c(int_st_r, ev, int_clr);
      int_mask_r <= wr_mask ? hwdata[INT_W-1:0] : int_mask_r;
    end
  end

  assign irq = |(int_st_r & int_mask_r);

  // ==========================================================
  // checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_run_low_both: assert property (!run_pin |-> !main_reset_n && !debug_port_reset_n)
    else $error("run low did not hold both resets");
  a_dbg_keeps_dp: assert property (debug_restart_req && run_ok && por_n_r
    |-> !main_reset_n && debug_port_reset_n)
    else $error("debug restart reset the wrong output");
  a_por_release: assert property ($rose(por_n_r) |-> $past(por_cnt_r) == CNT_W'(POR_ASSERT_CYC)
    && $past(good_s2_r))
    else $error("power-on released before its delay");
  a_por_sticky: assert property (por_n_r && bod_n_r |=> por_n_r)
    else $error("power-on output fell without brown-out");
  a_bod_trip: assert property ($fell(bod_n_r) |-> $past(bod_cnt_r) == CNT_W'(BOD_ASSERT_CYC)
    && $past(low_s2_r) && $past(bod_active))
    else $error("brown-out tripped early");
  a_bod_to_por: assert property (!bod_n_r |=> !por_n_r ##1 !por_n_r)
    else $error("brown-out did not restart power-on reset");
  sequence s_wait_done;
    bod_st_r == BOD_WAIT && wait_cnt_r == wait_target && por_n_r && bod_en_r;
  endsequence
  a_bod_activate: assert property ($rose(bod_active) |-> $past(wait_cnt_r) ==
    (($past(sel_act_r)) ? CNT_W'(BOD_ACTIVE_CNT) : CNT_W'(BOD_ENABLE_CNT)))
    else $error("detection active at wrong time");
  a_bod_wait_end: assert property (s_wait_done |=> bod_active)
    else $error("detection did not become active");
  a_bod_disabled: assert property (!bod_en_r |=> bod_n_r)
    else $error("disabled detection drove brown-out low");
  a_en_write: assert property (wr_ctrl && main_reset_n |=> bod_en_r == $past(hwdata[0]))
    else $error("enable bit ignored write");
  a_en_reset: assert property (!main_reset_n |=> bod_en_r)
    else $error("enable bit not set by reset");
  a_cause_onehot: assert property ($onehot0(cause_r))
    else $error("more than one cause flag set");
  a_restart_flag: assert property (debug_restart_req |=> restart_r)
    else $error("restart flag not set");
  a_run_release: assert property (!run_pin ##1 (run_pin && por_n_r && !debug_restart_req)[*3]
    |-> main_reset_n)
    else $error("reset not released after run high");

endmodule : clr_chip_reset
`default_nettype wire

// ### tb/clr_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module clr_far_side (
  input wire logic hclk,
  input wire logic main_reset_n,
  input wire logic debug_port_reset_n,
  input wire logic restart_cmd,
  output logic debug_restart_req,
  output int releases
);
  // ==========================================================
  // rescue port: it cannot request while its own reset holds it
  assign debug_restart_req = restart_cmd & debug_port_reset_n;
  // ==========================================================
  // sequencer: each rising main reset is one hand-over of the chip
  initial releases = 0;
  always @(posedge main_reset_n) begin
    releases++;
  end
endmodule : clr_far_side
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import clr_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, sup_good, sup_low, run_pin, restart_cmd;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  wire logic hreadyout, hresp, main_n, dbg_n, irq, req;
  wire logic [31:0] hrdata;
  int n_errors, checks, rel, n;

  clr_chip_reset #(.BOD_ACTIVE_CNT(20), .BOD_ENABLE_CNT(10)) dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .core_supply_good(sup_good), .core_supply_low(sup_low), .run_pin(run_pin),
    .debug_restart_req(req), .main_reset_n(main_n), .debug_port_reset_n(dbg_n),
    .irq(irq));

  clr_far_side far (
    .hclk(hclk), .main_reset_n(main_n), .debug_port_reset_n(dbg_n),
    .restart_cmd(restart_cmd), .debug_restart_req(req), .releases(rel));

  // ==========================================================
  // reporting
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask : chk

  // ==========================================================
  // bus master; every wait is bounded so a stuck slave ends the run
  task automatic hs_wait();
    int k;
    k = 0;
    do begin
      @(posedge hclk);
      k++;
    end while (hreadyout !== 1'b1 && k < 50);
    if (hreadyout !== 1'b1) begin
      chk("hready", 1'b1, hreadyout);
      give_verdict();
    end
  endtask : hs_wait

  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    htrans <= 2'b10;
    hwrite <= w;
    hs_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hs_wait();
    rd = hrdata;
    // a write lands at the data edge; one more edge before anyone looks at it
    if (w) begin
      @(posedge hclk);
    end
  endtask : bus

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(nm, e, rd & m);
    chk("hresp", 32'h0000_0000, 32'(hresp));
  endtask : rchk

  task automatic wait_main(input logic v, input int lim);
    n = 0;
    while (main_n !== v && n < lim) begin
      @(posedge hclk);
      n++;
    end
    chk("main wait", v, main_n);
    if (main_n !== v) give_verdict();
  endtask : wait_main

  // ==========================================================
  // scenarios
  task automatic sc_power_on();
    repeat (20) @(posedge hclk);
    chk("main in por", 1'b0, main_n);
    chk("dbg in por", 1'b0, dbg_n);
    hresetn <= 1'b1;
    repeat (100) @(posedge hclk);
    chk("main no supply", 1'b0, main_n);
    sup_good <= 1'b1;
    wait_main(1'b1, POR_ASSERT_CYC + 40);
    chk("por delay", 1'b1, n >= POR_ASSERT_CYC);
    chk("dbg released", 1'b1, dbg_n);
    chk("handover", 1, rel);
    rchk("status", ADDR_STATUS, 32'h0000_1707, 32'h0000_0103);
    rchk("ctrl rst", ADDR_CTRL, 32'hFFFF_FFFF, 32'h0000_0001);
    rchk("mask rst", ADDR_INT_MASK, 32'hFFFF_FFFF, 32'h0000_0000);
    rchk("unmapped", 8'h10, 32'hFFFF_FFFF, 32'h0000_0000);
    repeat (30) @(posedge hclk);
    rchk("active", ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    bus(ADDR_INT_MASK, 1'b1, 32'h0000_0001);
    chk("irq on", 1'b1, irq);
    bus(ADDR_INT_STATUS, 1'b1, 32'h0000_0001);
    chk("irq cleared", 1'b0, irq);
    bus(ADDR_INT_MASK, 1'b1, 32'h0000_0000);
  endtask : sc_power_on

  task automatic sc_run_pin();
    run_pin <= 1'b0;
    @(posedge hclk);
    #1;
    chk("run main", 1'b0, main_n);
    chk("run dbg", 1'b0, dbg_n);
    repeat (5) @(posedge hclk);
    run_pin <= 1'b1;
    wait_main(1'b1, 6);
    chk("run release", 1'b1, n <= 3);
    rchk("cause pin", ADDR_STATUS, 32'h0000_0700, 32'h0000_0200);
  endtask : sc_run_pin

  task automatic sc_debug();
    restart_cmd <= 1'b1;
    repeat (2) @(posedge hclk);
    chk("dbg main", 1'b0, main_n);
    chk("dbg port", 1'b1, dbg_n);
    repeat (4) @(posedge hclk);
    restart_cmd <= 1'b0;
    wait_main(1'b1, 10);
    rchk("cause dbg", ADDR_STATUS, 32'h0000_1700, 32'h0000_1400);
    rchk("int dbg", ADDR_INT_STATUS, 32'h0000_0004, 32'h0000_0004);
    bus(ADDR_STATUS, 1'b1, 32'h0000_1000);
    rchk("flag clr", ADDR_STATUS, 32'h0000_1000, 32'h0000_0000);
    bus(ADDR_INT_STATUS, 1'b1, 32'h0000_0007);
  endtask : sc_debug

  task automatic sc_brownout();
    bus(ADDR_CTRL, 1'b1, 32'h0000_0000);
    rchk("ctrl off", ADDR_CTRL, 32'h0000_0001, 32'h0000_0000);
    sup_low <= 1'b1;
    sup_good <= 1'b0;
    repeat (BOD_ASSERT_CYC + 50) @(posedge hclk);
    chk("stay up", 1'b1, main_n);
    rchk("bod forced", ADDR_STATUS, 32'h0000_0006, 32'h0000_0002);
    bus(ADDR_INT_MASK, 1'b1, 32'h0000_0002);
    bus(ADDR_CTRL, 1'b1, 32'h0000_0001);
    rchk("enable wait", ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    wait_main(1'b0, BOD_ASSERT_CYC + 60);
    chk("bod delay", 1'b1, n >= BOD_ASSERT_CYC);
    chk("bod dbg", 1'b0, dbg_n);
    chk("bod irq", 1'b1, irq);
    sup_low <= 1'b0;
    sup_good <= 1'b1;
    wait_main(1'b1, POR_ASSERT_CYC + 40);
    chk("por again", 1'b1, n >= POR_ASSERT_CYC);
    rchk("after bod", ADDR_STATUS, 32'h0000_0707, 32'h0000_0103);
    repeat (30) @(posedge hclk);
    rchk("reactive", ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
    bus(ADDR_INT_STATUS, 1'b1, 32'h0000_0002);
    chk("bod irq clr", 1'b0, irq);
    // a pin reset with detection off must turn it back on, after the enable delay
    bus(ADDR_CTRL, 1'b1, 32'h0000_0000);
    run_pin <= 1'b0;
    repeat (3) @(posedge hclk);
    run_pin <= 1'b1;
    wait_main(1'b1, 6);
    rchk("ctrl by reset", ADDR_CTRL, 32'h0000_0001, 32'h0000_0001);
    rchk("reset en wait", ADDR_STATUS, 32'h0000_0004, 32'h0000_0000);
    repeat (12) @(posedge hclk);
    rchk("reset en done", ADDR_STATUS, 32'h0000_0004, 32'h0000_0004);
  endtask : sc_brownout

  // ==========================================================
  // main sequence
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  initial begin
    {hresetn, hsel, hwrite, sup_good, sup_low, restart_cmd} = '0;
    run_pin = 1'b1;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    hsize = 3'b010;
    n_errors = 0;
    checks = 0;
    sc_power_on();
    sc_run_pin();
    sc_debug();
    sc_brownout();
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
